/* File: rtl/gpio_dual_edge_io_pkg.sv */
package gpio_dual_edge_io_pkg;

  // ==========================================================
  // Register bus.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;

  // ==========================================================
  // Data path widths and buffer depth.
  localparam int RX_W = 2;
  localparam int TX_W = 2;
  localparam int LVL_W = 2;
  localparam logic [LVL_W-1:0] BUF_FULL = 2'h2;
  localparam int BYP_W = 4;

  // Bypass destination bit positions.
  localparam int BYP_GLOBAL_CLOCK_NET = 0;
  localparam int BYP_GLOBAL_CONTROL_NET = 1;
  localparam int BYP_SYNTH = 2;
  localparam int BYP_CAM = 3;

  // ==========================================================
  // Input path modes.
  typedef enum logic [1:0] {
    IN_DIRECT = 2'h0,
    IN_REG = 2'h1,
    IN_DUAL_EDGE_IO = 2'h2,
    IN_BYPASS = 2'h3
  } in_mode_t;

  // Control register layout, low bits first from in_mode.
  typedef struct packed {
    logic [BYP_W-1:0] byp_dest;
    logic diff_pair;
    logic out_resync;
    logic out_dual_edge_io;
    logic out_inv;
    logic oe_reg;
    logic out_reg;
    logic in_resync;
    logic cap_fall;
    in_mode_t in_mode;
  } ctrl_t;

  localparam int CTRL_W = $bits(ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;

  // Status register layout.
  typedef struct packed {
    logic overrun;
    logic [LVL_W-1:0] level;
    logic oe;
    logic pad;
    logic [RX_W-1:0] last_rx;
  } status_t;

  localparam int STAT_W = $bits(status_t);
  localparam int OVR_BIT = 6;

endpackage : gpio_dual_edge_io_pkg

/* File: rtl/rx_buffer.sv */
// Two-entry buffer; head entry is the registered output.
module rx_buffer
  import gpio_dual_edge_io_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Filling side.
  input wire logic i_in_valid,
  input wire logic [RX_W-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side.
  output logic o_out_valid,
  output logic [RX_W-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level.
  output logic [LVL_W-1:0] o_level
);

  // ==========================================================
  // Storage.
  logic [RX_W-1:0] head_reg, head_next; // Oldest word.
  logic [RX_W-1:0] tail_reg, tail_next; // Second word.
  logic [LVL_W-1:0] cnt_reg, cnt_next; // Entries held.
  logic valid_reg, valid_next; // Head holds a word.
  logic push, pop;

  // Push only when room remains; pop when the reader takes the head.
  always_comb begin
    push = i_in_valid && (cnt_reg != BUF_FULL);
    pop = valid_reg && i_out_ready;
    head_next = head_reg;
    tail_next = tail_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      // Word joins behind whatever is held.
      if (cnt_reg == '0) begin
        head_next = i_in_data;
      end else begin
        tail_next = i_in_data;
      end
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      // Second word moves up.
      head_next = tail_reg;
      cnt_next = cnt_reg - 2'h1;
    end else if (pop && push) begin
      // Level unchanged; shift and refill.
      if (cnt_reg == BUF_FULL) begin
        head_next = tail_reg;
        tail_next = i_in_data;
      end else begin
        head_next = i_in_data;
      end
    end
    valid_next = (cnt_next != '0);
  end

  // Registers only.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      head_reg <= '0;
      tail_reg <= '0;
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
    end
  end

  assign o_in_ready = (cnt_reg != BUF_FULL);
  assign o_out_valid = valid_reg;
  assign o_out_data = head_reg;
  assign o_level = cnt_reg;

endmodule : rx_buffer

/* File: rtl/gpio_dual_edge_io_io_logic.sv */
module gpio_dual_edge_io_io_logic
  import gpio_dual_edge_io_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Register port.
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Core clocks, sampled as ordinary inputs.
  input wire logic i_launch_clk,
  input wire logic i_capture_clk,
  // Core transmit side.
  input wire logic [TX_W-1:0] i_tx_data,
  input wire logic i_drive_en,
  // Core receive side.
  output logic [RX_W-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  // Bypass destinations.
  output logic [BYP_W-1:0] o_bypass_path,
  // Pad.
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe
);

  // ==========================================================
  // Declarations.
  ctrl_t ctrl_reg, ctrl_next; // Configuration.
  logic [DATA_W-1:0] rdata_reg, rdata_next; // Read answer.
  logic ovr_reg, ovr_next; // Sticky sample loss flag.
  logic launch_q_reg, capture_q_reg; // Previous clock levels.
  logic pad_out_reg, pad_out_next; // Pad data register.
  logic oe_reg, oe_next; // Pad enable register.
  logic hold_fall_reg, hold_fall_next; // Resynced fall bit out.
  logic rise_hold_reg, rise_hold_next; // Rising input sample.
  logic fall_hold_reg, fall_hold_next; // Falling input sample.
  logic [RX_W-1:0] last_rx_reg, last_rx_next; // Last word pushed.
  logic l_rise, l_fall, c_rise, c_fall, sel_edge;
  logic in_dual_edge_io, out_dual_edge_io_eff, push, buf_ready;
  logic [RX_W-1:0] push_word;
  logic [LVL_W-1:0] level;
  status_t stat;

  // ==========================================================
  // Clock edge events and effective modes.
  always_comb begin
    l_rise = i_launch_clk && !launch_q_reg;
    l_fall = !i_launch_clk && launch_q_reg;
    c_rise = i_capture_clk && !capture_q_reg;
    c_fall = !i_capture_clk && capture_q_reg;
    sel_edge = ctrl_reg.cap_fall ? c_fall : c_rise;
    in_dual_edge_io = (ctrl_reg.in_mode == IN_DUAL_EDGE_IO) && !ctrl_reg.diff_pair;
    out_dual_edge_io_eff = ctrl_reg.out_reg && ctrl_reg.out_dual_edge_io && !ctrl_reg.diff_pair;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      launch_q_reg <= 1'b0;
      capture_q_reg <= 1'b0;
    end else begin
      launch_q_reg <= i_launch_clk;
      capture_q_reg <= i_capture_clk;
    end
  end

  // ==========================================================
  // Register port: control write, status read, sticky overrun.
  always_comb begin
    stat = '{overrun: ovr_reg, level: level, oe: oe_reg, pad: i_pad_in, last_rx: last_rx_reg};
    ctrl_next = ctrl_reg;
    ovr_next = ovr_reg;
    rdata_next = '0;
    if (i_wr) begin
      if (i_addr == CTRL_ADDR) begin
        ctrl_next = ctrl_t'(i_wdata[CTRL_W-1:0]);
      end else if (i_addr == STATUS_ADDR) begin
        // Writing one clears the overrun flag.
        if (i_wdata[OVR_BIT]) begin
          ovr_next = 1'b0;
        end
      end
    end
    // A loss in the clearing cycle still sets the flag.
    if (push && !buf_ready) begin
      ovr_next = 1'b1;
    end
    if (i_rd) begin
      if (i_addr == CTRL_ADDR) begin
        rdata_next = {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
      end else if (i_addr == STATUS_ADDR) begin
        rdata_next = {{(DATA_W-STAT_W){1'b0}}, stat};
      end else begin
        // Unmapped reads answer zero.
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= ctrl_t'(CTRL_RST);
      ovr_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      ovr_reg <= ovr_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Output and enable path, stepped by launch clock edges.
  always_comb begin
    pad_out_next = pad_out_reg;
    hold_fall_next = hold_fall_reg;
    if (!ctrl_reg.out_reg) begin
      // Unregistered: follow the core bit directly.
      pad_out_next = i_tx_data[0];
    end else if (out_dual_edge_io_eff) begin
      if (l_rise) begin
        pad_out_next = i_tx_data[0] ^ ctrl_reg.out_inv;
        if (ctrl_reg.out_resync) begin
          hold_fall_next = i_tx_data[1];
        end
      end else if (l_fall) begin
        if (ctrl_reg.out_resync) begin
          pad_out_next = hold_fall_reg ^ ctrl_reg.out_inv;
        end else begin
          pad_out_next = i_tx_data[1] ^ ctrl_reg.out_inv;
        end
      end
    end else if (l_rise) begin
      pad_out_next = i_tx_data[0] ^ ctrl_reg.out_inv;
    end
    if (ctrl_reg.oe_reg) begin
      oe_next = l_rise ? i_drive_en : oe_reg;
    end else begin
      oe_next = i_drive_en;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pad_out_reg <= 1'b0;
      oe_reg <= 1'b0;
      hold_fall_reg <= 1'b0;
    end else begin
      pad_out_reg <= pad_out_next;
      oe_reg <= oe_next;
      hold_fall_reg <= hold_fall_next;
    end
  end

  // ==========================================================
  // Input capture path, stepped by capture clock edges.
  always_comb begin
    push = 1'b0;
    push_word = '0;
    rise_hold_next = rise_hold_reg;
    fall_hold_next = fall_hold_reg;
    if (in_dual_edge_io) begin
      if (c_rise) begin
        rise_hold_next = i_pad_in;
        if (ctrl_reg.in_resync) begin
          // Fall sample waited half a cycle to join its rise sample.
          push = 1'b1;
          push_word = {fall_hold_reg, rise_hold_reg};
        end
      end else if (c_fall) begin
        fall_hold_next = i_pad_in;
        if (!ctrl_reg.in_resync) begin
          push = 1'b1;
          push_word = {i_pad_in, rise_hold_reg};
        end
      end
    end else if (ctrl_reg.in_mode == IN_DIRECT) begin
      push = 1'b1;
      push_word = {1'b0, i_pad_in};
    end else if (ctrl_reg.in_mode != IN_BYPASS) begin
      // Single-edge register, also used for DUAL_EDGE_IO on paired pins.
      push = sel_edge;
      push_word = {1'b0, i_pad_in};
    end
    last_rx_next = (push && buf_ready) ? push_word : last_rx_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_hold_reg <= 1'b0;
      fall_hold_reg <= 1'b0;
      last_rx_reg <= '0;
    end else begin
      rise_hold_reg <= rise_hold_next;
      fall_hold_reg <= fall_hold_next;
      last_rx_reg <= last_rx_next;
    end
  end

  // ==========================================================
  // Receive buffer toward the core; a full buffer drops the sample.
  rx_buffer u_rx_buffer (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(push),
    .i_in_data(push_word),
    .o_in_ready(buf_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready),
    .o_level(level)
  );

  // ==========================================================
  // Bypass: pad straight to the chosen destinations, no register.
  always_comb begin
    if (ctrl_reg.in_mode == IN_BYPASS) begin
      o_bypass_path = ctrl_reg.byp_dest & {BYP_W{i_pad_in}};
    end else begin
      o_bypass_path = '0;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_pad_out = pad_out_reg;
  assign o_pad_oe = oe_reg;

  // ==========================================================
  // Checks.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  rx_direct_a: assert property (
    (ctrl_reg.in_mode == IN_DIRECT && buf_ready) |=> last_rx_reg == {1'b0, $past(i_pad_in)})
    else $error("direct input word wrong");
  tx_rise_a: assert property (
    (ctrl_reg.out_reg && !out_dual_edge_io_eff && l_rise)
    |=> o_pad_out == ($past(i_tx_data[0]) ^ $past(ctrl_reg.out_inv)))
    else $error("registered output wrong");
  tx_fall_a: assert property (
    (out_dual_edge_io_eff && !ctrl_reg.out_resync && l_fall)
    |=> o_pad_out == ($past(i_tx_data[1]) ^ $past(ctrl_reg.out_inv)))
    else $error("fall bit not launched");
  byp_off_a: assert property (
    (ctrl_reg.in_mode != IN_BYPASS) |-> o_bypass_path == '0)
    else $error("bypass active outside bypass mode");
  byp_comb_a: assert property (
    (ctrl_reg.in_mode == IN_BYPASS && ctrl_reg.byp_dest[BYP_GLOBAL_CLOCK_NET]) |-> o_bypass_path[BYP_GLOBAL_CLOCK_NET] == i_pad_in)
    else $error("bypass not combinational");
  oe_hold_a: assert property (
    (ctrl_reg.oe_reg && !l_rise) |=> $stable(o_pad_oe))
    else $error("registered enable moved off edge");
  out_hold_a: assert property (
    (ctrl_reg.out_reg && !out_dual_edge_io_eff && !l_rise) |=> $stable(o_pad_out))
    else $error("output register moved off edge");
  cap_hold_a: assert property (
    (ctrl_reg.in_mode == IN_REG && !sel_edge) |=> $stable(last_rx_reg))
    else $error("capture off selected edge");
  out_resync_a: assert property (
    (out_dual_edge_io_eff && ctrl_reg.out_resync && l_rise) |=> hold_fall_reg == $past(i_tx_data[1]))
    else $error("fall bit not taken on rise");
  in_resync_a: assert property (
    (in_dual_edge_io && ctrl_reg.in_resync && c_fall) |=> fall_hold_reg == $past(i_pad_in) && !$past(push))
    else $error("fall sample not delayed");
  diff_pair_a: assert property (
    ctrl_reg.diff_pair |-> !in_dual_edge_io && !out_dual_edge_io_eff)
    else $error("dual edge on paired pin");
  oe_off_a: assert property (
    (!ctrl_reg.oe_reg && !i_drive_en) |=> !o_pad_oe)
    else $error("pad driven while disabled");

endmodule : gpio_dual_edge_io_io_logic

/* File: verification/pad_far_end.sv */
// ==========================================================
// Far end of the pad: an outside driver that lets go of the wire while the block drives it.
module pad_far_end (
  // Clock.
  input wire logic i_sys_clk,
  // Block side of the pad.
  input wire logic i_pad_out,
  input wire logic i_pad_oe,
  // Level and drive wanted by the bench.
  input wire logic i_level,
  input wire logic i_drive,
  // Resolved pad level.
  output logic o_pad
);
  timeunit 1ns;
  timeprecision 100ps;

  logic wander_reg = 1'h0; // Level of a wire that nobody drives.

  // An undriven wire has no pull, so it is shown as a level that flips every cycle.
  always @(posedge i_sys_clk) begin
    wander_reg <= ~wander_reg;
  end

  // The block owns the wire while its enable is high; otherwise the far end drives it if i_drive is high, and nobody drives it if not.
  assign o_pad = i_pad_oe ? i_pad_out : (i_drive ? i_level : wander_reg);
endmodule : pad_far_end

/* File: verification/gpio_dual_edge_io_io_logic_test.sv */
// ==========================================================
// Self-checking bench for the pin logic.
module gpio_dual_edge_io_io_logic_test
  import gpio_dual_edge_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0; // Clock, reset and strobes.
  logic lclk = 1'h0, cclk = 1'h0, drv = 1'h0, rdy = 1'h0, lvl = 1'h0; // Core side and pad level.
  logic [ADDR_W-1:0] addr = 4'h0; // Register address.
  logic [DATA_W-1:0] wd = 32'h0, rdata; // Register data.
  logic [TX_W-1:0] tx = 2'h0; // Transmit word.
  logic [RX_W-1:0] rxd; // Receive word.
  logic rxv, pin, pout, poe; // Receive valid and pad wires.
  logic [BYP_W-1:0] byp; // Bypass destinations.
  int n_fail = 0, n_tests = 0; // Mismatch and comparison counts.

  // The clock toggles every half period of 25 ns.
  always #12.5 sys_clk = ~sys_clk;

  gpio_dual_edge_io_io_logic gpio_dual_edge_io_io_logic_i (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_launch_clk(lclk), .i_capture_clk(cclk),
    .i_tx_data(tx), .i_drive_en(drv), .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rdy),
    .o_bypass_path(byp), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe));

  pad_far_end pad_far_end_i (.i_sys_clk(sys_clk), .i_pad_out(pout), .i_pad_oe(poe), .i_level(lvl),
    .i_drive(1'h1), .o_pad(pin));

  // ==========================================================
  // Shared helpers.
  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits a number of clock edges.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Writes one register in a single strobe cycle.
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    wr <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge sys_clk);
    wr <= 1'h0;
  endtask : reg_wr

  // Reads one register and compares the masked data in the cycle after the strobe.
  task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge sys_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'h0;
    #1;
    chk(rdata & mask, exp);
  endtask : reg_chk

  // Runs one capture clock period with the pad at r when the capture clock rises and f when it falls.
  task automatic cap_word(input logic r, input logic f);
    lvl <= r;
    cyc(2);
    cclk <= 1'h1;
    cyc(4);
    lvl <= f;
    cyc(2);
    cclk <= 1'h0;
    cyc(4);
  endtask : cap_word

  // Drains under one mode, captures one word, then checks the head of the receive buffer.
  task automatic rx_case(input logic [31:0] ctrl, input logic r, input logic f, input logic rs,
    input logic [1:0] exp);
    reg_wr(CTRL_ADDR, ctrl);
    rdy <= 1'h1;
    cap_word(r, r);
    rdy <= rs;
    cap_word(r, f);
    rdy <= 1'h0;
    cclk <= 1'h1;
    cyc(4);
    #1;
    chk({rxv, rxd}, {1'h1, exp});
    @(posedge sys_clk);
    cclk <= 1'h0;
    rdy <= 1'h1;
    cyc(6);
    rdy <= 1'h0;
  endtask : rx_case

  // Launches one word, flips the core inputs after the rise, and checks the pad at each half.
  task automatic tx_case(input logic [31:0] ctrl, input logic [1:0] t0, input logic en,
    input logic er, input logic ef, input logic eoe);
    reg_wr(CTRL_ADDR, ctrl);
    tx <= t0;
    drv <= en;
    cyc(4);
    lclk <= 1'h1;
    cyc(4);
    #1;
    chk({poe, pout}, {en, er});
    // The flip goes out on the next rising edge, so the design sees it one edge later.
    @(posedge sys_clk);
    tx <= ~t0;
    drv <= ~en;
    lclk <= 1'h0;
    cyc(4);
    #1;
    chk({poe, pout}, {eoe, ef});
    @(posedge sys_clk);
    drv <= 1'h0;
  endtask : tx_case

  // ==========================================================
  // Scenarios.
  // Reset value, full read-back and an unmapped address.
  task automatic test_regs();
    reg_chk(CTRL_ADDR, 32'hffff_ffff, 32'h0);
    reg_wr(CTRL_ADDR, 32'hffff_ffff);
    reg_chk(CTRL_ADDR, 32'hffff_ffff, 32'h3fff);
    reg_wr(4'h8, 32'h0);
    reg_chk(CTRL_ADDR, 32'hffff_ffff, 32'h3fff);
    reg_chk(4'h8, 32'hffff_ffff, 32'h0);
  endtask : test_regs

  // The pad reaches the chosen destinations within the same cycle, with no clock edge between.
  task automatic test_bypass();
    reg_wr(CTRL_ADDR, 32'h2803);
    lvl <= 1'h1;
    #1;
    chk(byp, 4'ha);
    @(posedge sys_clk);
    lvl <= 1'h0;
    #1;
    chk(byp, 4'h0);
  endtask : test_bypass

  // Direct input fills the buffer while the core stalls, then the sticky loss flag is cleared.
  task automatic test_overrun();
    @(posedge sys_clk);
    lvl <= 1'h1;
    rdy <= 1'h1;
    reg_wr(CTRL_ADDR, 32'h0);
    cyc(3);
    rdy <= 1'h0;
    cyc(6);
    #1;
    chk({rxv, rxd}, 3'h5);
    // Loss flag, level, pad high, enable low and last word one.
    reg_chk(STATUS_ADDR, 32'h7f, 32'h65);
    // A clear while samples are still being lost leaves the flag set.
    reg_wr(STATUS_ADDR, 32'h40);
    reg_chk(STATUS_ADDR, 32'h40, 32'h40);
    reg_wr(CTRL_ADDR, 32'h3);
    reg_wr(STATUS_ADDR, 32'h40);
    reg_chk(STATUS_ADDR, 32'h7f, 32'h25);
    @(posedge sys_clk);
    rdy <= 1'h1;
    cyc(4);
    rdy <= 1'h0;
    #1;
    chk(rxv, 1'h0);
  endtask : test_overrun

  // Every edge-clocked receive mode, each with a pattern that a wrong edge or slot would spoil.
  task automatic test_rx_modes();
    rx_case(32'h1, 1'h1, 1'h0, 1'h0, 2'h1);
    rx_case(32'h5, 1'h0, 1'h1, 1'h0, 2'h1);
    rx_case(32'h2, 1'h1, 1'h0, 1'h0, 2'h1);
    rx_case(32'h2, 1'h0, 1'h1, 1'h0, 2'h2);
    rx_case(32'ha, 1'h0, 1'h1, 1'h1, 2'h2);
    rx_case(32'h202, 1'h1, 1'h1, 1'h0, 2'h1);
  endtask : test_rx_modes

  // Every transmit and enable mode; the flip after the rise tells the modes apart.
  task automatic test_tx_modes();
    tx_case(32'h40, 2'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    tx_case(32'h10, 2'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    tx_case(32'h50, 2'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    tx_case(32'hb0, 2'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    tx_case(32'hd0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1);
    tx_case(32'h190, 2'h2, 1'h1, 1'h0, 1'h1, 1'h0);
    tx_case(32'h290, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1);
  endtask : test_tx_modes

  // ==========================================================
  // Verdict and end of run.
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Main sequence: outputs are quiet in reset, then every scenario runs in turn.
  initial begin
    cyc(2);
    #1;
    chk(rdata, 32'h0);
    chk({poe, rxv, pout, rxd, byp}, 9'h0);
    cyc(1);
    rst_b <= 1'h1;
    test_regs();
    test_bypass();
    test_overrun();
    test_rx_modes();
    test_tx_modes();
    finish_test();
  end

  // The whole sequence needs well under a thousand cycles, so a stop at five thousand means a hang.
  initial begin
    cyc(5000);
    n_fail++;
    finish_test();
  end
endmodule : gpio_dual_edge_io_io_logic_test
